/* File: include/itqc_defines.svh */
`ifndef ITQC_DEFINES_SVH
`define ITQC_DEFINES_SVH

// Register word offsets on the plain register port
`define ITQC_A_CTRL        8'h00
`define ITQC_A_START       8'h01
`define ITQC_A_MAXCNT      8'h02
`define ITQC_A_CURCNT      8'h03
`define ITQC_A_OVFCNT      8'h04
`define ITQC_A_QMODE       8'h05
`define ITQC_A_IRQ_STAT    8'h06
`define ITQC_A_IRQ_CLR     8'h07
`define ITQC_A_IRQ_EN      8'h08
`define ITQC_A_PL_SIZE     8'h10
`define ITQC_A_PL_COUNT    8'h11
`define ITQC_A_PL_FIN1     8'h12
`define ITQC_A_PL_FIN2     8'h13
`define ITQC_A_CAPS        8'h14
`define ITQC_A_MAX_CMD     8'h15
`define ITQC_A_MAX_ACK     8'h16
`define ITQC_A_NUM_STREAM  8'h17
`define ITQC_A_SIRM_ADDR   8'h18
`define ITQC_A_SIRM_LEN    8'h19
`define ITQC_A_EIRM_ADDR   8'h1A
`define ITQC_A_EIRM_LEN    8'h1B
`define ITQC_A_SPEED       8'h1C

// Control register field positions
`define ITQC_CTRL_USERCTL  0
`define ITQC_CTRL_MULTI    1
`define ITQC_CTRL_PASSIVE  2
`define ITQC_CTRL_SRC_LO   4
`define ITQC_CTRL_SRC_HI   7

// Interrupt status bits
`define ITQC_IRQ_DROP      0
`define ITQC_IRQ_SENT      1
`define ITQC_IRQ_EMPTY     2

`define ITQC_RST_CTRL      32'h0000_0000
`define ITQC_RST_WORD      32'h0000_0000
`endif

/* File: include/itqc_pkg.sv */
package itqc_pkg;
    typedef enum logic [1:0] {
        ITQC_IDLE  = 2'b00,
        ITQC_SEND  = 2'b01,
        ITQC_WAIT  = 2'b10
    } itqc_state_t;
endpackage

/* File: src/itqc_queue_ctrl.sv */
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "itqc_defines.svh"
module itqc_queue_ctrl #(
    parameter int          DEPTH        = 8,
    parameter int          CW           = 8,
    parameter bit          HAS_COMPRESS = 1'b1,
    parameter logic [31:0] PL_SIZE      = 32'h0010_0000,
    parameter logic [31:0] PL_COUNT     = 32'h0000_0004,
    parameter logic [31:0] PL_FIN1      = 32'h0000_0400,
    parameter logic [31:0] PL_FIN2      = 32'h0000_0000,
    parameter logic [2:0]  CAPS         = 3'b011,
    parameter logic [31:0] MAX_CMD      = 32'h0000_0400,
    parameter logic [31:0] MAX_ACK      = 32'h0000_0400,
    parameter logic [31:0] NUM_STREAM   = 32'h0000_0001,
    parameter logic [31:0] SIRM_ADDR    = 32'h0000_1000,
    parameter logic [31:0] SIRM_LEN     = 32'h0000_0040,
    parameter logic [31:0] EIRM_ADDR    = 32'h0000_2000,
    parameter logic [31:0] EIRM_LEN     = 32'h0000_0020
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        img_done,
    input  wire logic [3:0]  link_speed,
    input  wire logic        tx_ready,
    output logic             tx_send,
    output logic             tx_from_queue,
    output logic             irq
);
    import itqc_pkg::*;

    localparam logic [CW-1:0] MAXC = CW'(DEPTH);

    logic             user_ff;
    logic             multi_ff;
    logic             passive_ff;
    logic [3:0]       src_ff;
    logic [31:0]      qmode_ff;
    logic [CW-1:0]    cnt_ff;
    logic [31:0]      ovf_ff;
    logic [CW-1:0]    burst_ff;
    logic [2:0]       stat_ff;
    logic [2:0]       en_ff;
    logic [2:0]       spd_s1_ff;
    logic [2:0]       spd_s2_ff;
    logic [2:0]       spd_s3_ff;
    logic [3:0]       speed_ff;
    logic             tx_send_ff;
    logic             tx_q_ff;
    logic             irq_ff;
    logic [31:0]      rdata_ff;
    itqc_state_t      state_ff;
    itqc_state_t      nxt_state;

    logic wr_ctrl;
    logic wr_start;
    logic store;
    logic drop;
    logic deliver;
    logic direct_img;
    logic [31:0] nxt_rdata;

    assign wr_ctrl  = reg_wr && reg_addr == `ITQC_A_CTRL;
    assign wr_start = reg_wr && reg_addr == `ITQC_A_START;

    // Image routing: direct bypasses the queue, user mode caches it, or drops it when the queue is full
    assign direct_img = img_done && !user_ff;
    assign store      = img_done && user_ff && cnt_ff != MAXC;
    assign drop       = img_done && user_ff && cnt_ff == MAXC;
    // One queued image leaves per accepted send on the link
    assign deliver    = state_ff == ITQC_SEND && tx_ready;

    // Control fields written by software
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            user_ff    <= 1'b0;
            multi_ff   <= 1'b0;
            passive_ff <= 1'b0;
            src_ff     <= 4'h0;
            qmode_ff   <= `ITQC_RST_WORD;
        end else begin
            if (wr_ctrl) begin
                user_ff    <= reg_wdata[`ITQC_CTRL_USERCTL];
                multi_ff   <= reg_wdata[`ITQC_CTRL_MULTI];
                // Passive transfer only sticks in user mode
                passive_ff <= reg_wdata[`ITQC_CTRL_PASSIVE] &&
                              reg_wdata[`ITQC_CTRL_USERCTL];
                if (HAS_COMPRESS)
                    src_ff <= reg_wdata[`ITQC_CTRL_SRC_HI:`ITQC_CTRL_SRC_LO];
            end
            if (reg_wr && reg_addr == `ITQC_A_QMODE && HAS_COMPRESS)
                qmode_ff <= reg_wdata;
        end
    end

    // Delivery sequencer: burst size fixed when the start is taken
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ITQC_IDLE: begin
                if (wr_start && cnt_ff != '0)
                    nxt_state = ITQC_SEND;
            end
            ITQC_SEND: begin
                if (tx_ready)
                    nxt_state = ITQC_WAIT;
            end
            ITQC_WAIT: begin
                if (burst_ff != '0 && cnt_ff != '0)
                    nxt_state = ITQC_SEND;
                else
                    nxt_state = ITQC_IDLE;
            end
            default: nxt_state = ITQC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            state_ff <= ITQC_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Remaining images of the current burst
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            burst_ff <= '0;
        end else if (state_ff == ITQC_IDLE && wr_start && cnt_ff != '0) begin
            if (multi_ff)
                burst_ff <= cnt_ff - CW'(1);
            else
                burst_ff <= '0;
        end else if (state_ff == ITQC_WAIT && burst_ff != '0) begin
            burst_ff <= burst_ff - CW'(1);
        end
    end

    // Stored image count follows every store and every delivery
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            cnt_ff <= '0;
        else if (store && !deliver)
            cnt_ff <= cnt_ff + CW'(1);
        else if (deliver && !store)
            cnt_ff <= cnt_ff - CW'(1);
    end

    // Discard counter; a drop in the write cycle still counts
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            ovf_ff <= `ITQC_RST_WORD;
        else if (reg_wr && reg_addr == `ITQC_A_OVFCNT && HAS_COMPRESS)
            ovf_ff <= reg_wdata + {31'h0, drop};
        else if (drop)
            ovf_ff <= ovf_ff + 32'h0000_0001;
    end

    // Link outputs: a pulse per cycle with a direct or queued image, flagged if the queue delivered
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_send_ff <= 1'b0;
            tx_q_ff    <= 1'b0;
        end else begin
            tx_send_ff <= direct_img || deliver;
            tx_q_ff    <= deliver;
        end
    end

    // Speed input comes from another domain: three stages, agree to take
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spd_s1_ff <= 3'h0;
            spd_s2_ff <= 3'h0;
            spd_s3_ff <= 3'h0;
            speed_ff  <= 4'h0;
        end else begin
            spd_s1_ff <= link_speed[2:0];
            spd_s2_ff <= spd_s1_ff;
            spd_s3_ff <= spd_s2_ff;
            if (spd_s2_ff == spd_s3_ff)
                speed_ff <= {1'b0, spd_s3_ff};
        end
    end

    // Sticky events; a set in the clear cycle wins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_ff <= 3'h0;
            en_ff   <= 3'h0;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~((reg_wr && reg_addr == `ITQC_A_IRQ_CLR)
                        ? reg_wdata[2:0] : 3'h0))
                     | {state_ff == ITQC_WAIT && nxt_state == ITQC_IDLE,
                        deliver || direct_img, drop};
            if (reg_wr && reg_addr == `ITQC_A_IRQ_EN)
                en_ff <= reg_wdata[2:0];
            irq_ff  <= |(stat_ff & en_ff);
        end
    end

    // Read mux; unmapped or variant-absent words read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (reg_addr)
            `ITQC_A_CTRL: nxt_rdata = {24'h0, src_ff, 1'b0, passive_ff,
                                       multi_ff, user_ff};
            `ITQC_A_MAXCNT:     nxt_rdata = 32'(MAXC);
            `ITQC_A_CURCNT:     nxt_rdata = 32'(cnt_ff);
            `ITQC_A_OVFCNT:     nxt_rdata = HAS_COMPRESS ? ovf_ff : '0;
            `ITQC_A_QMODE:      nxt_rdata = qmode_ff;
            `ITQC_A_IRQ_STAT:   nxt_rdata = {29'h0, stat_ff};
            `ITQC_A_IRQ_EN:     nxt_rdata = {29'h0, en_ff};
            `ITQC_A_PL_SIZE:    nxt_rdata = PL_SIZE;
            `ITQC_A_PL_COUNT:   nxt_rdata = PL_COUNT;
            `ITQC_A_PL_FIN1:    nxt_rdata = PL_FIN1;
            `ITQC_A_PL_FIN2:    nxt_rdata = PL_FIN2;
            `ITQC_A_CAPS:       nxt_rdata = {29'h0, CAPS};
            `ITQC_A_MAX_CMD:    nxt_rdata = MAX_CMD;
            `ITQC_A_MAX_ACK:    nxt_rdata = MAX_ACK;
            `ITQC_A_NUM_STREAM: nxt_rdata = NUM_STREAM;
            `ITQC_A_SIRM_ADDR:  nxt_rdata = SIRM_ADDR;
            `ITQC_A_SIRM_LEN:   nxt_rdata = SIRM_LEN;
            `ITQC_A_EIRM_ADDR:  nxt_rdata = EIRM_ADDR;
            `ITQC_A_EIRM_LEN:   nxt_rdata = EIRM_LEN;
            `ITQC_A_SPEED:      nxt_rdata = {28'h0, speed_ff};
            default:            nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
            rdata_ff <= nxt_rdata;
        else
            rdata_ff <= 32'h0000_0000;
    end

    assign reg_rdata     = rdata_ff;
    assign tx_send       = tx_send_ff;
    assign tx_from_queue = tx_q_ff;
    assign irq           = irq_ff;

    // Checks
    a_direct_no_queue: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        direct_img |=> tx_send && !tx_from_queue && $stable(cnt_ff))
        else $error("direct image not forwarded at once");
    a_user_stores: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        store && !deliver |=> cnt_ff == $past(cnt_ff) + CW'(1))
        else $error("user mode image not stored");
    a_single_one: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state_ff == ITQC_IDLE && wr_start && cnt_ff != '0 && !multi_ff
        |=> burst_ff == '0)
        else $error("single block burst not one");
    a_multi_all: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state_ff == ITQC_IDLE && wr_start && cnt_ff != '0 && multi_ff
        |=> burst_ff == $past(cnt_ff) - CW'(1))
        else $error("multi block burst wrong size");
    a_start_sends: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state_ff == ITQC_IDLE && wr_start && cnt_ff != '0
        |=> state_ff == ITQC_SEND)
        else $error("start did not begin delivery");
    a_count_bound: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        cnt_ff <= MAXC)
        else $error("stored count above capacity");
    a_drop_counts: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        drop && !reg_wr |=> ovf_ff == $past(ovf_ff) + 32'h0000_0001)
        else $error("drop not counted");
    a_empty_start: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state_ff == ITQC_IDLE && wr_start && cnt_ff == '0 && !store
        |=> state_ff == ITQC_IDLE && cnt_ff == '0)
        else $error("empty start delivered");
    c_multi_burst: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_ff == ITQC_WAIT && burst_ff != '0 ##1 state_ff == ITQC_SEND);
    c_drop: cover property (@(posedge sys_clk) disable iff (!nrst) drop);
    c_direct: cover property (@(posedge sys_clk) disable iff (!nrst)
        direct_img);
endmodule

/* File: test/itqc_stream_sink.sv */
`timescale 1ns/1ns
// Stream engine model on the far side of the queue; may stall on demand
module itqc_stream_sink (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic       tx_send,
    input  wire logic       tx_from_queue,
    output logic            tx_ready,
    output logic [7:0]      n_sent,
    output logic [7:0]      n_queued
);
    logic       ready_ff;
    logic [7:0] sent_ff;
    logic [7:0] queued_ff;

    // Ready lags stall by one cycle, as a busy engine would
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ready_ff  <= 1'h0;
            sent_ff   <= 8'h00;
            queued_ff <= 8'h00;
        end else begin
            ready_ff  <= ~stall;
            sent_ff   <= sent_ff + {7'h00, tx_send};
            queued_ff <= queued_ff + {7'h00, tx_send & tx_from_queue};
        end
    end

    // Counts are cumulative; the bench checks running totals
    assign tx_ready = ready_ff;
    assign n_sent   = sent_ff;
    assign n_queued = queued_ff;
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`include "itqc_defines.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); \
    end end
module tb_top;
    localparam int          DEPTH    = 4;
    localparam logic [31:0] PL_SIZE  = 32'h0000_2000;
    localparam logic [2:0]  CAPS     = 3'h5;
    localparam logic [31:0] MAX_CMD  = 32'h0000_0200;
    localparam logic [31:0] SIRM_LEN = 32'h0000_0080;
    localparam logic [31:0] PL_COUNT = 32'h0000_0009;
    localparam logic [31:0] MAX_ACK  = 32'h0000_0100;
    localparam logic [31:0] EIRM_ADR = 32'h0000_3000;
    logic        sys_clk   = 1'h0;
    logic        nrst      = 1'h0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'h0;
    logic        reg_rd    = 1'h0;
    logic        img_done  = 1'h0;
    logic        stall     = 1'h0;
    logic [3:0]  link_speed = 4'h3;
    logic [31:0] reg_rdata;
    logic        tx_ready, tx_send, tx_from_queue, irq;
    logic [7:0]  n_sent, n_queued;
    int          miscompares = 0;
    int          n_compared  = 0;

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    itqc_queue_ctrl #(.DEPTH(DEPTH), .PL_SIZE(PL_SIZE), .CAPS(CAPS),
        .MAX_CMD(MAX_CMD), .SIRM_LEN(SIRM_LEN), .PL_COUNT(PL_COUNT),
        .MAX_ACK(MAX_ACK), .EIRM_ADDR(EIRM_ADR)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .img_done(img_done),
        .link_speed(link_speed), .tx_ready(tx_ready), .tx_send(tx_send),
        .tx_from_queue(tx_from_queue), .irq(irq));

    itqc_stream_sink sink (.sys_clk(sys_clk), .nrst(nrst), .stall(stall),
        .tx_send(tx_send), .tx_from_queue(tx_from_queue),
        .tx_ready(tx_ready), .n_sent(n_sent), .n_queued(n_queued));

    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One-cycle write; strobe dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge sys_clk);
        reg_wr    <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge sys_clk);
        reg_rd   <= 1'h0;
        #1;
        `CHK(reg_rdata, e)
        // Data must fall back to zero the cycle after
        @(posedge sys_clk);
        #1;
        `CHK(reg_rdata, 32'h0000_0000)
    endtask

    task automatic pulse_img(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            img_done <= 1'h1;
            @(posedge sys_clk);
            img_done <= 1'h0;
        end
    endtask

    // Bounded wait for the sink's count, then a quiet spell for extras
    task automatic wsent(input logic [7:0] n);
        for (int i = 0; i < 60 && n_sent !== n; i++) @(posedge sys_clk);
        if (n_sent !== n) begin
            miscompares++;
            $display("unexpected at %0t: send wait ran out", $time);
            final_report();
        end
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic t_regs();
        rchk(`ITQC_A_MAXCNT, 32'(DEPTH));
        wr(`ITQC_A_MAXCNT, 32'hFFFF_FFFF);
        rchk(`ITQC_A_MAXCNT, 32'(DEPTH));
        rchk(`ITQC_A_PL_SIZE, PL_SIZE);
        rchk(`ITQC_A_PL_COUNT, PL_COUNT);
        rchk(`ITQC_A_CAPS, {29'h0, CAPS});
        rchk(`ITQC_A_MAX_CMD, MAX_CMD);
        rchk(`ITQC_A_MAX_ACK, MAX_ACK);
        rchk(`ITQC_A_SIRM_LEN, SIRM_LEN);
        rchk(`ITQC_A_EIRM_ADDR, EIRM_ADR);
        rchk(`ITQC_A_SPEED, 32'h0000_0003);
        rchk(8'h3F, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_direct();
        wr(`ITQC_A_CTRL, 32'h0000_0000);
        @(posedge sys_clk);
        img_done <= 1'h1;
        @(posedge sys_clk);
        img_done <= 1'h0;
        #1;
        `CHK(tx_send, 1'h1)
        `CHK(tx_from_queue, 1'h0)
        rchk(`ITQC_A_CURCNT, 32'h0000_0000);
        $display("test direct done");
    endtask

    task automatic t_single();
        // User mode goes in before passive transfer is asked for
        wr(`ITQC_A_CTRL, 32'h0000_0001);
        wr(`ITQC_A_CTRL, 32'h0000_0035);
        rchk(`ITQC_A_CTRL, 32'h0000_0035);
        wr(`ITQC_A_START, 32'h0000_0001);
        repeat (10) @(posedge sys_clk);
        `CHK(n_sent, 8'h01)
        rchk(`ITQC_A_CURCNT, 32'h0000_0000);
        pulse_img(3);
        repeat (4) @(posedge sys_clk);
        `CHK(n_sent, 8'h01)
        rchk(`ITQC_A_CURCNT, 32'h0000_0003);
        wr(`ITQC_A_START, 32'h0000_0001);
        wsent(8'h02);
        `CHK(n_queued, 8'h01)
        rchk(`ITQC_A_CURCNT, 32'h0000_0002);
        $display("test single done");
    endtask

    task automatic t_multi();
        wr(`ITQC_A_IRQ_CLR, 32'h0000_0007);
        wr(`ITQC_A_IRQ_EN, 32'h0000_0004);
        wr(`ITQC_A_CTRL, 32'h0000_0037);
        stall <= 1'h1;
        wr(`ITQC_A_START, 32'h0000_0001);
        repeat (10) @(posedge sys_clk);
        `CHK(n_sent, 8'h02)
        stall <= 1'h0;
        wsent(8'h04);
        `CHK(n_queued, 8'h03)
        rchk(`ITQC_A_CURCNT, 32'h0000_0000);
        `CHK(irq, 1'h1)
        rchk(`ITQC_A_IRQ_STAT, 32'h0000_0006);
        wr(`ITQC_A_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'h0)
        wr(`ITQC_A_IRQ_CLR, 32'h0000_0007);
        wr(`ITQC_A_IRQ_EN, 32'h0000_0004);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'h0)
        $display("test multi done");
    endtask

    task automatic t_full();
        // Passive asked for without user mode must not stick
        wr(`ITQC_A_CTRL, 32'h0000_0004);
        rchk(`ITQC_A_CTRL, 32'h0000_0000);
        wr(`ITQC_A_CTRL, 32'h0000_0001);
        pulse_img(DEPTH + 1);
        rchk(`ITQC_A_CURCNT, 32'(DEPTH));
        rchk(`ITQC_A_OVFCNT, 32'h0000_0001);
        rchk(`ITQC_A_IRQ_STAT, 32'h0000_0001);
        wr(`ITQC_A_OVFCNT, 32'h0000_0005);
        rchk(`ITQC_A_OVFCNT, 32'h0000_0005);
        wr(`ITQC_A_QMODE, 32'h0000_0001);
        rchk(`ITQC_A_QMODE, 32'h0000_0001);
        $display("test full done");
    endtask

    // Reset for eight cycles, then run each scenario in turn
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_direct();
        t_single();
        t_multi();
        t_full();
        final_report();
    end
endmodule
